// ---- ssd_dir_map.sv ----
// output stage mapping command-space torque onto the shaft sense
// assumes the direction select is frozen after the power-up capture
module ssd_dir_map (
  // clock and reset
  input  wire logic                                  sys_clk,
  input  wire logic                                  nrst,
  // sense select and command-space torque
  input  wire logic                                  rotDir,
  input  wire logic signed [ssd_pkg::TORQUE_W-1:0]   cmdTorque,
  // encoder phases from the motor
  input  wire logic                                  encAIn,
  input  wire logic                                  encBIn,
  // shaft-space torque and emitted encoder phases
  output logic signed      [ssd_pkg::TORQUE_W-1:0]   torqueOut,
  output logic                                       encAOut,
  output logic                                       encBOut
);

  ssd_pkg::ssd_dir_t q;
  ssd_pkg::ssd_dir_t next_q;

  // select 1 turns a positive command clockwise; encoder phases untouched
  always_comb begin
    next_q.torque = rotDir ? ssd_pkg::neg_sat(cmdTorque) : cmdTorque; // [RL1]
    next_q.encA   = encAIn; // [RL3]
    next_q.encB   = encBIn; // [RL3]
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign torqueOut = q.torque;
  assign encAOut   = q.encA;
  assign encBOut   = q.encB;

  a_dir_sense: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL1]
    ##1 torqueOut == ($past(rotDir) ? ssd_pkg::neg_sat($past(cmdTorque)) : $past(cmdTorque)))
    else $error("torque sense does not follow direction select");

  a_enc_unchanged: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL3]
    ##1 (encAOut == $past(encAIn)) && (encBOut == $past(encBIn)))
    else $error("encoder phases altered by direction select");

endmodule

// ---- ssd_motor_model.sv ----
// behavioural motor and power stage seen from the stop control
// assumes shaft-space torque and the captured sense select as inputs
module ssd_motor_model #(
  parameter int COAST_DIV = 4
) (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                nrst,
  // drive from the power stage
  input  wire logic signed [ssd_pkg::TORQUE_W-1:0] torque,
  input  wire logic                                powered,
  input  wire logic                                braked,
  input  wire logic                                rotDir,
  // feedback to the drive
  output logic                                     stopped,
  output logic                                     movingFwd,
  output logic                                     encA,
  output logic                                     encB
);
  int         vel;
  int         div;
  logic [1:0] pos;

  // speed integrator; the brake halts fast, coasting only every few cycles
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vel <= 0;
      div <= 0;
      pos <= 2'h0;
    end else begin
      div <= (div + 1) % COAST_DIV;
      if (powered && torque > 0 && vel < 4) begin
        vel <= vel + 1;
      end else if (powered && torque < 0 && vel > -4) begin
        vel <= vel - 1;
      end else if (!powered && vel != 0 && (braked || div == 0)) begin
        vel <= (vel > 0) ? vel - 1 : vel + 1;
      end
      if (vel > 0) begin
        pos <= pos + 2'h1;
      end else if (vel < 0) begin
        pos <= pos - 2'h1;
      end
    end
  end

  // rest, command-space sense and quadrature phases
  assign stopped   = (vel == 0);
  assign movingFwd = (vel > 0) ^ rotDir;
  assign encA      = pos[1];
  assign encB      = pos[1] ^ pos[0];
endmodule

// ---- ssd_pin_sync.sv ----
// three-stage synchroniser for the active-low limit and latch pins
// assumes asynchronous pins; outputs active-high levels on sys_clk
module ssd_pin_sync (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // raw pins, low means active
  input  wire logic [ssd_pkg::PIN_W-1:0] pinN,
  // filtered active-high levels
  output logic      [ssd_pkg::PIN_W-1:0] active
);

  ssd_pkg::ssd_sync_t q;
  ssd_pkg::ssd_sync_t next_q;

  // shift chain; a change counts once stages two and three agree
  always_comb begin
    next_q    = q;
    next_q.s1 = pinN;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < ssd_pkg::PIN_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.level[i] = q.s3[i];
      end
    end
  end

  // state register, pins idle high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{s1: ssd_pkg::PIN_IDLE, s2: ssd_pkg::PIN_IDLE, s3: ssd_pkg::PIN_IDLE, level: ssd_pkg::PIN_IDLE};
    end else begin
      q <= next_q;
    end
  end

  // low level on the pin is the active state
  assign active = ~q.level; // [RL13]

  a_sync_agree: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL13]
    ($past(q.s2) != $past(q.s3)) |-> $stable(q.level))
    else $error("pin level changed without stage agreement");

endmodule

// ---- ssd_pkg.sv ----
// shared constants, types and helpers of the servo stop and direction control
// assumes a 100 MHz sys_clk domain with an active-low asynchronous reset nrst
package ssd_pkg;

  // widths
  localparam int TORQUE_W = 16;
  localparam int PIN_W    = 6;

  // index of each limit and latch pin inside the pin group
  localparam int PIN_FWD  = 0;
  localparam int PIN_REV  = 1;
  localparam int PIN_DEC  = 2;
  localparam int PIN_EXTA = 3;
  localparam int PIN_EXTB = 4;
  localparam int PIN_EXTC = 5;

  // reset values of the power-up selects and idle level of the pins
  localparam logic       ROT_DIR_RST    = 1'h0;
  localparam logic [1:0] ALARM_SEL_RST  = 2'h2;
  localparam logic [1:0] OT_SEL_RST     = 2'h0;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3F;

  // alarm stop select codes
  localparam logic [1:0] ALARM_DB_HOLD    = 2'h0;
  localparam logic [1:0] ALARM_DB_RELEASE = 2'h1;
  localparam logic [1:0] ALARM_COAST      = 2'h2;

  // overtravel stop select codes
  localparam logic [1:0] OT_BY_ALARM = 2'h0;
  localparam logic [1:0] OT_EMG_LOCK = 2'h1;
  localparam logic [1:0] OT_EMG_FREE = 2'h2;

  // control modes
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED    = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;

  // torque limits
  localparam logic signed [TORQUE_W-1:0] TORQUE_MAX = 16'h7FFF;
  localparam logic signed [TORQUE_W-1:0] TORQUE_MIN = 16'h8000;

  typedef enum logic [3:0] {
    ST_CFG       = 4'h0,
    ST_IDLE      = 4'h1,
    ST_RUN       = 4'h2,
    ST_DB_STOP   = 4'h3,
    ST_COAST     = 4'h4,
    ST_EMG_DECEL = 4'h5,
    ST_LOCK      = 4'h6,
    ST_DB_HOLD   = 4'h7,
    ST_FREE      = 4'h8
  } ssd_state_t;

  typedef struct packed {
    logic       rotDir;
    logic [1:0] alarmSel;
    logic [1:0] otSel;
  } ssd_cfg_t;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] level;
  } ssd_sync_t;

  typedef struct packed {
    logic signed [TORQUE_W-1:0] torque;
    logic                       encA;
    logic                       encB;
  } ssd_dir_t;

  typedef struct packed {
    ssd_state_t                 st;
    ssd_cfg_t                   cfg;
    logic signed [TORQUE_W-1:0] torque;
    logic                       power;
    logic                       dynBrake;
    logic                       lock;
    logic                       posLoop;
  } ssd_core_t;

  // negate without wrapping the most negative value
  function automatic logic signed [TORQUE_W-1:0] neg_sat(input logic signed [TORQUE_W-1:0] v);
    neg_sat = (v == TORQUE_MIN) ? TORQUE_MAX : -v;
  endfunction

  // map unused select codes onto the defaults
  function automatic ssd_cfg_t cfg_clean(input ssd_cfg_t c);
    cfg_clean = c;
    if (c.alarmSel == 2'h3) begin
      cfg_clean.alarmSel = ALARM_SEL_RST;
    end
    if (c.otSel == 2'h3) begin
      cfg_clean.otSel = OT_SEL_RST;
    end
  endfunction

endpackage

// ---- ssd_stop_ctrl.sv ----
// stop behaviour and rotation sense control of the servo drive
// assumes limit pins are asynchronous, all other inputs are on sys_clk,
// and the power-up selects are held steady around reset release

// Contract
// [RL1] Direction select 0 makes a positive command turn the shaft counterclockwise, 1 clockwise.
// [RL2] The direction select starts at 0 and a new value only acts after a restart.
// [RL3] Reversing the sense with select 1 leaves the emitted A/B encoder phases unchanged.
// [RL4] Servo off or an alarm always triggers the stop chosen by the alarm stop select.
// [RL5] Alarm stop select 0 stops on the dynamic brake and keeps the brake on at rest.
// [RL6] Alarm stop select 1 stops on the dynamic brake and releases it once stopped.
// [RL7] Alarm stop select 2 lets the motor coast with no brake, and 2 is the default.
// [RL8] Overtravel select 0, the default, stops per the alarm stop select and then releases the servo.
// [RL9] Overtravel select 1 decelerates with the emergency stop torque and then holds in servo lock.
// [RL10] Overtravel select 2 decelerates with the emergency stop torque, then frees the servo, brake off.
// [RL11] While stopped in servo lock in position control the position loop is off.
// [RL12] In torque mode an overtravel stop follows the alarm stop select, ignoring the overtravel select.
// [RL13] Forward, reverse, origin and three latch inputs are active at low level by default.
// [RL14] All three selects are sampled only at reset, so later changes wait for a restart.
module ssd_stop_ctrl (
  // clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  // power-up selects, captured once after reset
  input  wire ssd_pkg::ssd_cfg_t                    cfgIn,
  // controller commands and mode
  input  wire logic                                 servoOn,
  input  wire logic                                 alarmIn,
  input  wire logic [1:0]                           ctrlMode,
  input  wire logic signed [ssd_pkg::TORQUE_W-1:0]  cmdTorque,
  input  wire logic signed [ssd_pkg::TORQUE_W-1:0]  emergencyStopTorque,
  // motor feedback, command-space sense
  input  wire logic                                 motorStopped,
  input  wire logic                                 motorMovingFwd,
  input  wire logic                                 encAIn,
  input  wire logic                                 encBIn,
  // limit and latch pins, active low
  input  wire logic [ssd_pkg::PIN_W-1:0]            limitPinN,
  // power stage
  output logic signed [ssd_pkg::TORQUE_W-1:0]       torqueOut,
  output logic                                      powerEnable,
  output logic                                      dynBrakeOn,
  output logic                                      brakeInterlockOut,
  // status
  output logic                                      servoLockFlag,
  output logic                                      posLoopEnable,
  output logic                                      rotDirActive,
  output ssd_pkg::ssd_state_t                       stopState,
  // filtered pin levels and encoder outputs
  output logic                                      forwardDriveProhibit,
  output logic                                      reverseDriveProhibit,
  output logic                                      originDecelSwitch,
  output logic                                      externalLatchA,
  output logic                                      externalLatchB,
  output logic                                      externalLatchC,
  output logic                                      encAOut,
  output logic                                      encBOut
);

  ssd_pkg::ssd_core_t          q;
  ssd_pkg::ssd_core_t          next_q;
  logic [ssd_pkg::PIN_W-1:0]   pinActive;
  logic                        stopReq;
  logic                        otHit;
  logic                        torqueMode;
  logic                        cmdPos;
  logic                        cmdNeg;

  // pin synchroniser, active-low pins become active-high levels
  ssd_pin_sync u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinN    (limitPinN),
    .active  (pinActive)
  );

  // stop causes
  assign stopReq    = !servoOn || alarmIn; // [RL4]
  assign torqueMode = (ctrlMode == ssd_pkg::MODE_TORQUE);
  assign cmdPos     = !cmdTorque[ssd_pkg::TORQUE_W-1] && (cmdTorque != '0);
  assign cmdNeg     = cmdTorque[ssd_pkg::TORQUE_W-1];
  assign otHit      = (pinActive[ssd_pkg::PIN_FWD] && cmdPos) || (pinActive[ssd_pkg::PIN_REV] && cmdNeg);

  // next state and registered outputs
  always_comb begin
    ssd_pkg::ssd_state_t alarmPath;
    alarmPath = (q.cfg.alarmSel == ssd_pkg::ALARM_COAST) ? ssd_pkg::ST_COAST : ssd_pkg::ST_DB_STOP; // [RL7]
    next_q    = q;
    unique case (q.st)
      ssd_pkg::ST_CFG: begin
        next_q.cfg = ssd_pkg::cfg_clean(cfgIn); // [RL14]
        next_q.st  = ssd_pkg::ST_IDLE;
      end
      ssd_pkg::ST_IDLE: begin
        if (!stopReq) begin
          next_q.st = ssd_pkg::ST_RUN;
        end
      end
      ssd_pkg::ST_RUN: begin
        if (stopReq) begin
          next_q.st = alarmPath; // [RL4]
        end else if (otHit) begin
          if (torqueMode || q.cfg.otSel == ssd_pkg::OT_BY_ALARM) begin
            next_q.st = alarmPath; // [RL8] [RL12]
          end else begin
            next_q.st = ssd_pkg::ST_EMG_DECEL; // [RL9] [RL10]
          end
        end
      end
      ssd_pkg::ST_DB_STOP: begin
        if (motorStopped) begin
          next_q.st = (q.cfg.alarmSel == ssd_pkg::ALARM_DB_HOLD) ? ssd_pkg::ST_DB_HOLD : ssd_pkg::ST_FREE; // [RL5] [RL6]
        end
      end
      ssd_pkg::ST_COAST: begin
        if (motorStopped) begin
          next_q.st = ssd_pkg::ST_FREE;
        end
      end
      ssd_pkg::ST_EMG_DECEL: begin
        if (stopReq) begin
          next_q.st = alarmPath;
        end else if (motorStopped) begin
          next_q.st = (q.cfg.otSel == ssd_pkg::OT_EMG_LOCK) ? ssd_pkg::ST_LOCK : ssd_pkg::ST_FREE; // [RL9] [RL10]
        end
      end
      ssd_pkg::ST_LOCK: begin
        if (stopReq) begin
          next_q.st = alarmPath;
        end else if (!otHit) begin
          next_q.st = ssd_pkg::ST_RUN;
        end
      end
      ssd_pkg::ST_DB_HOLD, ssd_pkg::ST_FREE: begin
        if (!stopReq && !otHit) begin
          next_q.st = ssd_pkg::ST_RUN;
        end
      end
      default: begin
        next_q.st = ssd_pkg::ST_IDLE; // unused codes recover
      end
    endcase

    // power stage drive follows the state being entered
    next_q.power    = (next_q.st == ssd_pkg::ST_RUN) || (next_q.st == ssd_pkg::ST_EMG_DECEL)
                      || (next_q.st == ssd_pkg::ST_LOCK);
    next_q.dynBrake = (next_q.st == ssd_pkg::ST_DB_STOP) || (next_q.st == ssd_pkg::ST_DB_HOLD); // [RL5] [RL6]
    next_q.lock     = (next_q.st == ssd_pkg::ST_LOCK); // [RL9]
    next_q.posLoop  = (next_q.st == ssd_pkg::ST_RUN) && (ctrlMode == ssd_pkg::MODE_POSITION); // [RL11]
    unique case (next_q.st)
      ssd_pkg::ST_RUN:       next_q.torque = cmdTorque;
      ssd_pkg::ST_EMG_DECEL: next_q.torque = motorMovingFwd ? ssd_pkg::neg_sat(emergencyStopTorque)
                                                            : emergencyStopTorque; // [RL9] [RL10]
      default:               next_q.torque = '0;
    endcase
  end

  // state register; selects start at their defaults until captured
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: ssd_pkg::ST_CFG,
             cfg: '{rotDir: ssd_pkg::ROT_DIR_RST, alarmSel: ssd_pkg::ALARM_SEL_RST, otSel: ssd_pkg::OT_SEL_RST},
             torque: '0, power: 1'b0, dynBrake: 1'b0, lock: 1'b0, posLoop: 1'b0}; // [RL2]
    end else begin
      q <= next_q;
    end
  end

  // shaft sense and encoder output stage
  ssd_dir_map u_dir (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .rotDir    (q.cfg.rotDir),
    .cmdTorque (q.torque),
    .encAIn    (encAIn),
    .encBIn    (encBIn),
    .torqueOut (torqueOut),
    .encAOut   (encAOut),
    .encBOut   (encBOut)
  );

  // status and power outputs
  assign powerEnable       = q.power;
  assign dynBrakeOn        = q.dynBrake;
  assign brakeInterlockOut = q.power; // holding brake released only while powered
  assign servoLockFlag     = q.lock;
  assign posLoopEnable     = q.posLoop;
  assign rotDirActive      = q.cfg.rotDir;
  assign stopState         = q.st;

  // filtered pin levels
  assign forwardDriveProhibit = pinActive[ssd_pkg::PIN_FWD];
  assign reverseDriveProhibit = pinActive[ssd_pkg::PIN_REV];
  assign originDecelSwitch    = pinActive[ssd_pkg::PIN_DEC];
  assign externalLatchA       = pinActive[ssd_pkg::PIN_EXTA];
  assign externalLatchB       = pinActive[ssd_pkg::PIN_EXTB];
  assign externalLatchC       = pinActive[ssd_pkg::PIN_EXTC];

  // capture and freeze of the selects
  a_cfg_capture: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL2]
    (q.st == ssd_pkg::ST_IDLE && $past(q.st) == ssd_pkg::ST_CFG) |-> (q.cfg == ssd_pkg::cfg_clean($past(cfgIn))))
    else $error("selects not captured after reset");

  a_cfg_frozen: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL14]
    (q.st != ssd_pkg::ST_CFG) |=> $stable(q.cfg))
    else $error("selects changed during operation");

  // servo off and alarm stops
  a_servo_off_stop: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL4]
    (q.st == ssd_pkg::ST_RUN && stopReq) |=> !powerEnable)
    else $error("servo still powered after stop request");

  a_db_hold_kept: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL5]
    (q.st == ssd_pkg::ST_DB_STOP && motorStopped && q.cfg.alarmSel == ssd_pkg::ALARM_DB_HOLD)
    |=> (dynBrakeOn && !powerEnable) [*2])
    else $error("dynamic brake not held at rest");

  a_db_released: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL6]
    (q.st == ssd_pkg::ST_DB_STOP && motorStopped && q.cfg.alarmSel == ssd_pkg::ALARM_DB_RELEASE)
    |=> (stopState == ssd_pkg::ST_FREE) && !dynBrakeOn)
    else $error("dynamic brake not released at rest");

  a_coast_no_brake: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL7]
    (q.st == ssd_pkg::ST_RUN && stopReq && q.cfg.alarmSel == ssd_pkg::ALARM_COAST)
    |=> (stopState == ssd_pkg::ST_COAST) && !dynBrakeOn && !powerEnable)
    else $error("coast stop applied a brake or power");

  // overtravel stops
  a_ot_by_alarm: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL8]
    (q.st == ssd_pkg::ST_RUN && !stopReq && otHit && q.cfg.otSel == ssd_pkg::OT_BY_ALARM)
    |=> !powerEnable && ((stopState == ssd_pkg::ST_COAST) || (stopState == ssd_pkg::ST_DB_STOP)))
    else $error("overtravel did not follow alarm stop");

  a_ot_lock: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL9]
    (q.st == ssd_pkg::ST_EMG_DECEL && !stopReq && motorStopped && q.cfg.otSel == ssd_pkg::OT_EMG_LOCK)
    |=> servoLockFlag && powerEnable && !dynBrakeOn && (stopState == ssd_pkg::ST_LOCK))
    else $error("no servo lock after emergency deceleration");

  a_ot_free: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL10]
    (q.st == ssd_pkg::ST_EMG_DECEL && !stopReq && motorStopped && q.cfg.otSel == ssd_pkg::OT_EMG_FREE)
    |=> (stopState == ssd_pkg::ST_FREE) && !dynBrakeOn && !powerEnable)
    else $error("servo not freed after emergency deceleration");

  a_lock_no_posloop: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL11]
    servoLockFlag |-> !posLoopEnable)
    else $error("position loop active in servo lock");

  a_torque_mode_ot: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL12]
    (q.st == ssd_pkg::ST_RUN && !stopReq && otHit && torqueMode)
    |=> (stopState != ssd_pkg::ST_EMG_DECEL) && !powerEnable)
    else $error("torque mode used overtravel select");

  a_pin_active_low: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL13]
    ((limitPinN[ssd_pkg::PIN_FWD] == 1'b0) [*5]) |-> forwardDriveProhibit)
    else $error("low forward pin not seen as active");

endmodule

// ---- ssd_stop_ctrl_test.sv ----
// self-checking bench of the stop and direction control
// assumes the motor model closes the loop from power stage to feedback
module ssd_stop_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    ssd_pkg::ssd_cfg_t   cfg;
    logic [1:0]          mode;
    logic [1:0]          ev;
    ssd_pkg::ssd_state_t st;
    logic                saw;
    logic                lock;
    logic                pow;
    logic                brk;
  } ssd_row_t;

  logic                                sys_clk = 1'b0;
  logic                                nrst    = 1'b0;
  ssd_pkg::ssd_cfg_t                   cfgIn   = '0;
  logic                                servoOn = 1'b0;
  logic                                alarmIn = 1'b0;
  logic [1:0]                          ctrlMode = 2'h0;
  logic signed [ssd_pkg::TORQUE_W-1:0] cmdTorque = 16'h0000;
  logic [ssd_pkg::PIN_W-1:0]           limitPinN = 6'h3F;
  logic signed [ssd_pkg::TORQUE_W-1:0] torqueOut;
  logic signed [ssd_pkg::TORQUE_W-1:0] estTq = 16'h0200;
  logic signed [ssd_pkg::TORQUE_W-1:0] tq;
  logic                                motorStopped, motorMovingFwd, encAIn, encBIn;
  logic                                powerEnable, dynBrakeOn, brakeInterlockOut;
  logic                                servoLockFlag, posLoopEnable, rotDirActive;
  ssd_pkg::ssd_state_t                 stopState;
  logic [ssd_pkg::PIN_W-1:0]           pinLvl;
  logic                                encAOut, encBOut, saw, pa, pb;
  int                                  fail_count = 0;
  int                                  cmp_count = 0;
  ssd_row_t                            rows [8];

  // clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  ssd_stop_ctrl dut (
    .sys_clk(sys_clk), .nrst(nrst), .cfgIn(cfgIn), .servoOn(servoOn), .alarmIn(alarmIn),
    .ctrlMode(ctrlMode), .cmdTorque(cmdTorque), .emergencyStopTorque(estTq),
    .motorStopped(motorStopped), .motorMovingFwd(motorMovingFwd), .encAIn(encAIn),
    .encBIn(encBIn), .limitPinN(limitPinN), .torqueOut(torqueOut), .powerEnable(powerEnable),
    .dynBrakeOn(dynBrakeOn), .brakeInterlockOut(brakeInterlockOut), .servoLockFlag(servoLockFlag),
    .posLoopEnable(posLoopEnable), .rotDirActive(rotDirActive), .stopState(stopState),
    .forwardDriveProhibit(pinLvl[0]), .reverseDriveProhibit(pinLvl[1]),
    .originDecelSwitch(pinLvl[2]), .externalLatchA(pinLvl[3]), .externalLatchB(pinLvl[4]),
    .externalLatchC(pinLvl[5]), .encAOut(encAOut), .encBOut(encBOut)
  );

  ssd_motor_model motor (
    .sys_clk(sys_clk), .nrst(nrst), .torque(torqueOut), .powered(powerEnable),
    .braked(dynBrakeOn), .rotDir(rotDirActive), .stopped(motorStopped),
    .movingFwd(motorMovingFwd), .encA(encAIn), .encB(encBIn)
  );

  // compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset for 8 cycles with a given select set
  task automatic boot(input ssd_pkg::ssd_cfg_t c);
    @(posedge sys_clk);
    nrst <= 1'b0;
    cfgIn <= c;
    servoOn <= 1'b0;
    alarmIn <= 1'b0;
    limitPinN <= 6'h3F;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask

  // watchdog
  initial begin
    #200us;
    fail_count++;
    close_out();
  end

  // main sequence: table rows, then hand-written cases
  initial begin
    // cfg, mode, event (0 off, 1 alarm, 2 fwd, 3 rev), end state, brake seen, lock, power, brake
    rows[0] = {5'b0_00_00, 2'h0, 2'h0, ssd_pkg::ST_DB_HOLD, 4'b1001};
    rows[1] = {5'b0_01_00, 2'h0, 2'h1, ssd_pkg::ST_FREE, 4'b1000};
    rows[2] = {5'b0_10_00, 2'h0, 2'h0, ssd_pkg::ST_FREE, 4'b0000};
    rows[3] = {5'b0_11_11, 2'h0, 2'h1, ssd_pkg::ST_FREE, 4'b0000};
    rows[4] = {5'b0_00_00, 2'h0, 2'h2, ssd_pkg::ST_DB_HOLD, 4'b1001};
    rows[5] = {5'b1_00_01, 2'h0, 2'h2, ssd_pkg::ST_LOCK, 4'b0110};
    rows[6] = {5'b0_01_10, 2'h1, 2'h3, ssd_pkg::ST_FREE, 4'b0000};
    rows[7] = {5'b0_01_01, 2'h2, 2'h2, ssd_pkg::ST_FREE, 4'b1000};
    foreach (rows[i]) begin
      boot(rows[i].cfg);
      ctrlMode <= rows[i].mode;
      cmdTorque <= (rows[i].ev == 2'h3) ? 16'hFF00 : 16'h0100;
      @(posedge sys_clk);
      servoOn <= 1'b1;
      for (int n = 0; n < 20 && stopState !== ssd_pkg::ST_RUN; n++) @(negedge sys_clk);
      repeat (8) @(negedge sys_clk);
      chk("torqueOut", rows[i].cfg.rotDir ? -cmdTorque : cmdTorque, torqueOut);
      chk("rotDirActive", rows[i].cfg.rotDir, rotDirActive);
      chk("posLoopEnable", rows[i].mode == ssd_pkg::MODE_POSITION, posLoopEnable);
      @(posedge sys_clk);
      case (rows[i].ev)
        2'h0: servoOn <= 1'b0;
        2'h1: alarmIn <= 1'b1;
        2'h2: limitPinN[ssd_pkg::PIN_FWD] <= 1'b0;
        default: limitPinN[ssd_pkg::PIN_REV] <= 1'b0;
      endcase
      saw = 1'b0;
      tq = 16'h0000;
      for (int n = 0; n < 80 && stopState !== rows[i].st; n++) begin
        @(negedge sys_clk);
        saw = saw | dynBrakeOn;
        if (stopState === ssd_pkg::ST_EMG_DECEL) begin
          tq = torqueOut;
        end
      end
      repeat (2) @(negedge sys_clk);
      chk("stopState", rows[i].st, stopState);
      chk("brakeSeen", rows[i].saw, saw);
      chk("emgTorque", (rows[i].ev[1] && rows[i].mode != ssd_pkg::MODE_TORQUE
          && rows[i].cfg.otSel inside {2'h1, 2'h2}) ? estTq : 16'h0000, tq);
      chk("servoLockFlag", rows[i].lock, servoLockFlag);
      chk("powerEnable", rows[i].pow, powerEnable);
      chk("brakeInterlockOut", rows[i].pow, brakeInterlockOut);
      chk("dynBrakeOn", rows[i].brk, dynBrakeOn);
      chk("posLoopEnable", 16'h0000, posLoopEnable);
    end
    // reset values and capture only at restart
    boot(5'b1_10_00);
    @(negedge sys_clk);
    chk("stopState", ssd_pkg::ST_CFG, stopState);
    chk("rotDirActive", 16'h0000, rotDirActive);
    repeat (3) @(posedge sys_clk);
    cfgIn <= 5'b0_00_01;
    repeat (5) @(negedge sys_clk);
    chk("rotDirActive", 16'h0001, rotDirActive);
    // each limit and latch pin active at low level
    for (int p = 0; p < ssd_pkg::PIN_W; p++) begin
      @(posedge sys_clk);
      limitPinN <= ~(6'h01 << p);
      repeat (8) @(negedge sys_clk);
      chk("pinLevels", 6'h01 << p, pinLvl);
      @(posedge sys_clk);
      limitPinN <= 6'h3F;
      repeat (8) @(negedge sys_clk);
    end
    // encoder phases pass unchanged with the sense reversed
    @(posedge sys_clk);
    servoOn <= 1'b1;
    cmdTorque <= 16'h0100;
    repeat (6) @(negedge sys_clk);
    for (int n = 0; n < 24; n++) begin
      pa = encAIn;
      pb = encBIn;
      @(negedge sys_clk);
      chk("encAOut", pa, encAOut);
      chk("encBOut", pb, encBOut);
    end
    // servo lock goes back to run once the limit clears
    boot(5'b0_00_01);
    ctrlMode <= ssd_pkg::MODE_POSITION;
    @(posedge sys_clk);
    servoOn <= 1'b1;
    repeat (12) @(posedge sys_clk);
    limitPinN[ssd_pkg::PIN_FWD] <= 1'b0;
    for (int n = 0; n < 80 && stopState !== ssd_pkg::ST_LOCK; n++) @(negedge sys_clk);
    chk("servoLockFlag", 16'h0001, servoLockFlag);
    chk("posLoopEnable", 16'h0000, posLoopEnable);
    @(posedge sys_clk);
    limitPinN <= 6'h3F;
    for (int n = 0; n < 20 && stopState !== ssd_pkg::ST_RUN; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk("stopState", ssd_pkg::ST_RUN, stopState);
    chk("posLoopEnable", 16'h0001, posLoopEnable);
    close_out();
  end
endmodule
